//--- csc_pkg.sv
// shared constants for the core sequencing and configuration block
package csc_pkg;
  localparam int PC_W = 10;
  localparam int STK_W = 12;
  localparam logic [9:0] PC_RESET = 10'h3ff;
  localparam logic [7:0] CFG_RESET = 8'hff;
  localparam logic [7:0] TRIM_RESET = 8'hfe;
  localparam logic [4:0] ADDR_INDIRECT = 5'h00;
  localparam logic [4:0] ADDR_LOW_BYTE = 5'h02;
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [4:0] ADDR_POINTER = 5'h04;
  localparam logic [4:0] ADDR_TRIM = 5'h05;
  localparam int BIT_WAKE = 7;
  localparam int BIT_PULLUP = 6;
  localparam int BIT_TSRC = 5;
  localparam int BIT_TEDGE = 4;
  localparam int BIT_PSA = 3;
  localparam int BIT_PAGE = 5;
  localparam int TRIM_LSB = 1;
  typedef enum logic [2:0] {
    CSC_OP_NONE = 3'b000,
    CSC_OP_JUMP = 3'b001,
    CSC_OP_CALL = 3'b010,
    CSC_OP_RETURN_WITH_LITERAL = 3'b011,
    CSC_OP_CFG = 3'b100
  } csc_op_t;
endpackage

//--- csc_stack.sv
// two-level return stack
`timescale 1ns/1ps
module csc_stack (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [11:0] i_data,
  output logic [11:0] o_top
);
  logic [11:0] lvl1_reg;
  logic [11:0] lvl2_reg;
  logic [11:0] lvl1_next;
  logic [11:0] lvl2_next;
  always_comb begin
    lvl1_next = lvl1_reg;
    lvl2_next = lvl2_reg;
    if (i_push) begin
      // deepest entry lost on overflow, no flag
      lvl2_next = lvl1_reg;
      lvl1_next = i_data;
    end else if (i_pop) begin
      lvl1_next = lvl2_reg; // level two kept for repeat pops
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lvl1_reg <= 12'h000;
      lvl2_reg <= 12'h000;
    end else begin
      lvl1_reg <= lvl1_next; // two 12-bit levels
      lvl2_reg <= lvl2_next;
    end
  end
  assign o_top = lvl1_reg;
endmodule

//--- csc_regfile.sv
// 32-entry data register memory with registered read
`timescale 1ns/1ps
module csc_regfile (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [4:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [4:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:31];
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

//--- csc_core.sv
// core sequencing: program counter, stack, config, trim, indirect access
//
// Functional notes
// - config loads from accumulator on its instruction; reset sets all ones
// - config bit 7 one disables wake on pin change
// - config bit 6 one disables weak pull-ups
// - bit 5 one: timer on pin edges, overriding direction; else on steps
// - bit 4 picks pin edge: one falling, zero rising
// - bit 3 gives prescaler to watchdog when one, timer when zero
// - rate field divides timer by 2..256 or watchdog by 1..128
// - trim holds signed seven bits in 7:1; bit 0 reads zero
// - counter steps by one on each step unless loaded
// - direct jump loads counter bits 8:0 from instruction
// - page bit supplies counter bit 9 on jump, call, low byte write
// - low byte maps onto counter bits 7:0
// - call or low byte write takes bits 7:0 and clears bit 8
// - reset puts counter at last location; then rolls over to 00h
// - reset clears page bit so jumps land in page zero
// - return stack has two levels of twelve bits
// - call pushes level one down and stores counter plus one
// - return pops level one, copies level two up, keeps level two
// - return with literal loads accumulator with the literal
// - no overflow or underflow indication exists
// - window access acts on register addressed by pointer
// - indirect read with pointer zero returns 00h
// - indirect write to the window itself changes nothing
// - pointer low five bits select data addresses 00h to 1Fh
// - page bit one selects 200h-3FFh, zero 000h-1FFh
`timescale 1ns/1ps
module csc_core (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_step,
  input wire logic [2:0] i_op,
  input wire logic [8:0] i_imm,
  input wire logic [7:0] i_acc,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_ext_clk_pin,
  output logic [9:0] o_pc,
  output logic [7:0] o_rdata,
  output logic o_acc_load,
  output logic [7:0] o_acc_data,
  output logic o_wake_on_change_disable,
  output logic o_pullup_disable,
  output logic o_timer_ext_override,
  output logic o_timer_tick,
  output logic o_watchdog_tick,
  output logic [6:0] o_trim
);
  logic [9:0] pc_reg, pc_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] trim_reg, trim_next;
  logic page_reg, page_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] rdata_reg, rdata_next;
  logic acc_ld_reg, acc_ld_next;
  logic [7:0] acc_reg, acc_next;
  logic sync1_reg, sync2_reg, pin_prev_reg;
  logic [7:0] pre_reg, pre_next;
  logic ttick_reg, ttick_next, wtick_reg, wtick_next;
  logic [11:0] stk_top;
  logic [11:0] push_data;
  logic push, pop;
  logic [4:0] eff_addr;
  logic is_ind, mem_we, self_ind;
  logic [7:0] mem_rdata;
  logic rd_pend_reg, rd_mem_reg, rd_pend_next, rd_mem_next;
  logic [7:0] rd_fix_reg, rd_fix_next;
  logic pin_edge, src_tick, pre_hit;
  logic [7:0] pre_mask;
  csc_pkg::csc_op_t op;

  assign op = csc_pkg::csc_op_t'(i_op);
  assign is_ind = (i_addr == csc_pkg::ADDR_INDIRECT);
  assign eff_addr = is_ind ? ptr_reg[4:0] : i_addr;
  // pointer at zero makes the window address itself
  assign self_ind = is_ind && (ptr_reg[4:0] == csc_pkg::ADDR_INDIRECT);
  // writes to the window itself are dropped
  assign mem_we = i_step && i_wr && !self_ind;
  // stack moves only on a step, never on a bare read
  assign push = i_step && (op == csc_pkg::CSC_OP_CALL);
  assign pop = i_step && (op == csc_pkg::CSC_OP_RETURN_WITH_LITERAL);
  assign push_data = {2'b00, pc_reg + 10'h001};

  // return address is the step after the call; top two bits unused
  csc_stack csc_stack_inst (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_push(push),
    .i_pop(pop),
    .i_data(push_data),
    .o_top(stk_top)
  );

  // one resolved address serves both ports, so indirect and direct agree
  csc_regfile csc_regfile_inst (
    .i_clk(i_clk),
    .i_we(mem_we),
    .i_waddr(eff_addr),
    .i_wdata(i_wdata),
    .i_raddr(eff_addr),
    .o_rdata(mem_rdata)
  );

  // program counter, page, pointer, config and trim
  always_comb begin
    pc_next = pc_reg;
    page_next = page_reg;
    ptr_next = ptr_reg;
    cfg_next = cfg_reg;
    trim_next = trim_reg;
    acc_ld_next = 1'b0;
    acc_next = acc_reg;
    if (i_step) begin
      pc_next = pc_reg + 10'h001; // wraps 3ffh to 000h
      case (op)
        csc_pkg::CSC_OP_JUMP: begin
          // page bit gives bit 9, selecting the page
          pc_next = {page_reg, i_imm};
        end
        csc_pkg::CSC_OP_CALL: begin
          pc_next = {page_reg, 1'b0, i_imm[7:0]};
        end
        csc_pkg::CSC_OP_RETURN_WITH_LITERAL: begin
          pc_next = stk_top[9:0];
          acc_ld_next = 1'b1;
          acc_next = i_imm[7:0];
        end
        csc_pkg::CSC_OP_CFG: begin
          cfg_next = i_acc;
        end
        default: begin
        end
      endcase
      // a low byte write lands last, so it wins over a jump or call
      if (i_wr) begin
        case (eff_addr)
          csc_pkg::ADDR_LOW_BYTE: begin
            if (!self_ind) begin
              pc_next = {page_reg, 1'b0, i_wdata};
            end
          end
          csc_pkg::ADDR_STATUS: begin
            page_next = i_wdata[csc_pkg::BIT_PAGE];
          end
          csc_pkg::ADDR_POINTER: begin
            ptr_next = {3'b111, i_wdata[4:0]};
          end
          csc_pkg::ADDR_TRIM: begin
            // only software alters the trim
            trim_next = {i_wdata[7:1], 1'b0};
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc_reg <= csc_pkg::PC_RESET;
      page_reg <= 1'b0;
      ptr_reg <= 8'he0;
      cfg_reg <= csc_pkg::CFG_RESET;
      trim_reg <= csc_pkg::TRIM_RESET;
      acc_ld_reg <= 1'b0;
      acc_reg <= 8'h00;
    end else begin
      pc_reg <= pc_next;
      page_reg <= page_next;
      ptr_reg <= ptr_next;
      cfg_reg <= cfg_next;
      trim_reg <= trim_next;
      acc_ld_reg <= acc_ld_next;
      acc_reg <= acc_next;
    end
  end

  // read path: memory has one cycle of latency, so the control
  // registers are staged alongside to keep all reads aligned
  always_comb begin
    rd_pend_next = i_rd;
    rd_mem_next = 1'b0;
    rd_fix_next = 8'h00;
    rdata_next = rdata_reg;
    if (i_rd) begin
      case (eff_addr)
        csc_pkg::ADDR_INDIRECT: rd_fix_next = 8'h00;
        csc_pkg::ADDR_LOW_BYTE: rd_fix_next = pc_reg[7:0];
        csc_pkg::ADDR_STATUS: rd_fix_next = {2'b00, page_reg, 5'h00};
        csc_pkg::ADDR_POINTER: rd_fix_next = ptr_reg;
        csc_pkg::ADDR_TRIM: rd_fix_next = trim_reg; // bit 0 is zero
        default: rd_mem_next = 1'b1;
      endcase
    end
    if (rd_pend_reg) begin
      rdata_next = rd_mem_reg ? mem_rdata : rd_fix_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_pend_reg <= 1'b0;
      rd_mem_reg <= 1'b0;
      rd_fix_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      rd_pend_reg <= rd_pend_next;
      rd_mem_reg <= rd_mem_next;
      rd_fix_reg <= rd_fix_next;
      rdata_reg <= rdata_next;
    end
  end

  // timer source, edge and shared prescaler; the pin is asynchronous
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= i_ext_clk_pin;
      sync2_reg <= sync1_reg;
      pin_prev_reg <= sync2_reg;
    end
  end

  // falling edge when bit 4 is one, rising when zero
  assign pin_edge = cfg_reg[csc_pkg::BIT_TEDGE] ?
    (pin_prev_reg && !sync2_reg) : (!pin_prev_reg && sync2_reg);
  // pin edges or the instruction cycle clock
  assign src_tick = cfg_reg[csc_pkg::BIT_TSRC] ? pin_edge : i_step;
  // timer divides by 2^(n+1); watchdog by 2^n
  // the watchdog mask is the timer mask shifted down by one
  always_comb begin
    case (cfg_reg[2:0])
      3'h0: pre_mask = 8'h01;
      3'h1: pre_mask = 8'h03;
      3'h2: pre_mask = 8'h07;
      3'h3: pre_mask = 8'h0f;
      3'h4: pre_mask = 8'h1f;
      3'h5: pre_mask = 8'h3f;
      3'h6: pre_mask = 8'h7f;
      3'h7: pre_mask = 8'hff;
      default: pre_mask = 8'hff;
    endcase
    if (cfg_reg[csc_pkg::BIT_PSA]) begin
      pre_mask = {1'b0, pre_mask[7:1]};
    end
  end
  // counter keeps running across rate changes; first period may be short
  assign pre_hit = ((pre_reg & pre_mask) == pre_mask);

  // watchdog base tick is the instruction step
  always_comb begin
    pre_next = pre_reg;
    ttick_next = 1'b0;
    wtick_next = 1'b0;
    if (cfg_reg[csc_pkg::BIT_PSA]) begin
      // watchdog owns prescaler, timer runs undivided
      ttick_next = src_tick;
      if (i_step) begin
        pre_next = pre_hit ? 8'h00 : pre_reg + 8'h01;
        wtick_next = pre_hit;
      end
    end else begin
      wtick_next = i_step;
      if (src_tick) begin
        pre_next = pre_hit ? 8'h00 : pre_reg + 8'h01;
        ttick_next = pre_hit;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_reg <= 8'h00;
      ttick_reg <= 1'b0;
      wtick_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      ttick_reg <= ttick_next;
      wtick_reg <= wtick_next;
    end
  end

  // every output is a register or a register bit
  assign o_pc = pc_reg;
  assign o_rdata = rdata_reg;
  assign o_acc_load = acc_ld_reg;
  assign o_acc_data = acc_reg;
  assign o_wake_on_change_disable = cfg_reg[csc_pkg::BIT_WAKE];
  assign o_pullup_disable = cfg_reg[csc_pkg::BIT_PULLUP];
  assign o_timer_ext_override = cfg_reg[csc_pkg::BIT_TSRC];
  assign o_timer_tick = ttick_reg;
  assign o_watchdog_tick = wtick_reg;
  assign o_trim = trim_reg[7:1];
endmodule

//--- csc_core_checker.sv
// assertion checker for the core sequencing block
`timescale 1ns/1ps
module csc_core_checker (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_step,
  input wire logic [2:0] i_op,
  input wire logic [8:0] i_imm,
  input wire logic [7:0] i_acc,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [9:0] o_pc,
  input wire logic [7:0] o_rdata,
  input wire logic o_acc_load,
  input wire logic [7:0] o_acc_data,
  input wire logic o_wake_on_change_disable,
  input wire logic o_pullup_disable,
  input wire logic o_timer_ext_override,
  input wire logic [6:0] o_trim
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic st;
  logic lw;
  logic tw;
  logic cf;
  logic rl;
  // writes are left out so a low byte store cannot mask a step
  assign st = i_step && !i_wr;
  assign lw = i_step && i_wr && i_addr == csc_pkg::ADDR_LOW_BYTE;
  assign tw = i_step && i_wr && i_addr == csc_pkg::ADDR_TRIM;
  assign cf = i_step && i_op == csc_pkg::CSC_OP_CFG;
  assign rl = i_step && i_op == csc_pkg::CSC_OP_RETURN_WITH_LITERAL;
  sequence s_trim_rd;
    i_rd && i_addr == csc_pkg::ADDR_TRIM;
  endsequence
  a_pc_advance: assert property (st && i_op == csc_pkg::CSC_OP_NONE
    |=> o_pc == $past(o_pc) + 10'h001) else $error("pc not advanced");
  a_pc_hold: assert property (!i_step |=> $stable(o_pc))
    else $error("pc moved without a step");
  a_jump_load: assert property (st && i_op == csc_pkg::CSC_OP_JUMP
    |=> o_pc[8:0] == $past(i_imm)) else $error("jump target wrong");
  a_call_load: assert property (st && i_op == csc_pkg::CSC_OP_CALL
    |=> o_pc[8:0] == {1'b0, $past(i_imm[7:0])}) else $error("call bad");
  a_low_byte: assert property (lw
    |=> o_pc[8:0] == {1'b0, $past(i_wdata)}) else $error("low byte bad");
  a_cfg_bits: assert property (cf
    |=> {o_wake_on_change_disable, o_pullup_disable, o_timer_ext_override}
    == $past(i_acc[7:5])) else $error("config bits wrong");
  a_acc_literal: assert property (rl
    |=> o_acc_load && o_acc_data == $past(i_imm[7:0]))
    else $error("literal not loaded");
  a_trim_write: assert property (tw
    |=> o_trim == $past(i_wdata[7:1])) else $error("trim not written");
  a_trim_hold: assert property (!(tw || (i_step && i_wr && i_addr ==
    csc_pkg::ADDR_INDIRECT)) |=> $stable(o_trim)) else $error("trim moved");
  a_trim_read: assert property (s_trim_rd
    |-> ##2 o_rdata == {$past(o_trim, 2), 1'b0}) else $error("trim read bad");
endmodule

//--- csc_tb.sv
// self-checking bench for the core sequencing block
`timescale 1ns/1ps
module tb;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_step = 1'b0;
  logic [2:0] i_op = 3'h0;
  logic [8:0] i_imm = 9'h000;
  logic [7:0] i_acc = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_ext_clk_pin = 1'b0;
  logic [9:0] o_pc;
  logic [7:0] o_rdata, o_acc_data;
  logic o_acc_load, o_wake_on_change_disable, o_pullup_disable;
  logic o_timer_ext_override, o_timer_tick, o_watchdog_tick;
  logic [6:0] o_trim;
  int fails = 0;
  int n_checks = 0;
  int tt = 0;
  int wt = 0;
  int t0, t1, e;
  logic [9:0] q_pc[$];
  logic [7:0] q_rd[$];
  logic [9:0] pc_m;
  logic [11:0] l1, l2;
  logic pg, st_d, rd1, rd2;
  logic [7:0] ptr, trim, mem[32];
  csc_core csc_core_inst (.*);
  initial forever #5 i_clk = ~i_clk;
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one cycle of stimulus; expectations come from a reference model
  task automatic cy(input logic s, input logic [2:0] op,
    input logic [8:0] im, input logic w, input logic r,
    input logic [4:0] a, input logic [7:0] d);
    logic [9:0] n;
    logic [7:0] v;
    i_step = s;
    i_op = op;
    i_imm = im;
    i_acc = im[7:0];
    i_wr = w;
    i_rd = r;
    i_addr = a;
    i_wdata = d;
    case (a)
      5'h00: v = (ptr[4:0] == 5'h00) ? 8'h00 : mem[ptr[4:0]];
      5'h02: v = pc_m[7:0];
      5'h03: v = {2'b00, pg, 5'h00};
      5'h04: v = ptr;
      5'h05: v = trim;
      default: v = mem[a];
    endcase
    if (r) q_rd.push_back(v);
    if (s) begin
      n = pc_m + 10'h001;
      if (op == 3'h1) n = {pg, im};
      if (op == 3'h2) begin
        n = {pg, 1'b0, im[7:0]};
        l2 = l1;
        l1 = {2'b00, pc_m + 10'h001};
      end
      if (op == 3'h3) begin
        n = l1[9:0];
        l1 = l2;
      end
      if (w && a == 5'h02) n = {pg, 1'b0, d};
      pc_m = n;
      q_pc.push_back(n);
    end
    // page change takes effect from the next step on
    if (s && w) begin
      case (a)
        5'h00: if (ptr[4:0] != 5'h00) mem[ptr[4:0]] = d;
        5'h03: pg = d[5];
        5'h04: ptr = {3'h7, d[4:0]};
        5'h05: trim = {d[7:1], 1'b0};
        default: mem[a] = d;
      endcase
    end
    @(posedge i_clk);
    #1;
  endtask
  task automatic rst();
    i_rst_b = 1'b0;
    pc_m = 10'h3ff;
    pg = 1'b0;
    ptr = 8'he0;
    trim = 8'hfe;
    l1 = 12'h000;
    l2 = 12'h000;
    q_pc.delete();
    q_rd.delete();
    repeat (3) cy(0, 0, 0, 0, 0, 0, 0);
    i_rst_b = 1'b1;
    chk(o_pc === 10'h3ff && o_trim === 7'h7f, "reset pc trim");
    chk({o_wake_on_change_disable, o_pullup_disable, o_timer_ext_override}
      === 3'h7, "reset config");
  endtask
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_d <= 1'b0;
      rd1 <= 1'b0;
      rd2 <= 1'b0;
    end else begin
      st_d <= i_step;
      rd1 <= i_rd;
      rd2 <= rd1;
    end
  end
  always @(posedge i_clk) begin
    tt <= tt + int'(o_timer_tick);
    wt <= wt + int'(o_watchdog_tick);
  end
  always @(negedge i_clk) begin
    if (st_d) chk(o_pc === q_pc.pop_front(), "pc mismatch");
    if (rd2) chk(o_rdata === q_rd.pop_front(), "read mismatch");
  end
  initial begin
    #500000;
    fails++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h34dc));
    rst();
    cy(1, 0, 0, 0, 0, 0, 0);
    cy(1, 1, 9'h1ff, 0, 0, 0, 0);
    cy(1, 0, 0, 1, 1, 5'h03, 8'h20);
    cy(1, 1, 9'h055, 0, 1, 5'h03, 0);
    for (int k = 0; k < 3; k++) begin
      cy(1, 2, 9'(k + 64), 0, 0, 0, 0);
    end
    for (int k = 0; k < 3; k++) begin
      cy(1, 3, 9'(k + 16), 0, 0, 0, 0);
    end
    cy(1, 1, 9'h1ff, 1, 0, 5'h02, 8'h9c);
    cy(1, 0, 0, 1, 0, 5'h02, 8'($urandom));
    cy(0, 0, 0, 0, 1, 5'h02, 0);
    cy(1, 0, 0, 1, 0, 5'h05, 8'h81);
    cy(1, 0, 0, 1, 1, 5'h05, 8'h7e);
    cy(0, 0, 0, 0, 1, 5'h05, 0);
    cy(1, 0, 0, 1, 0, 5'h07, 8'($urandom));
    cy(1, 0, 0, 1, 0, 5'h04, 8'h07);
    cy(0, 0, 0, 0, 1, 5'h00, 0);
    cy(1, 0, 0, 1, 0, 5'h04, 8'h1f);
    cy(1, 0, 0, 1, 0, 5'h00, 8'($urandom));
    cy(0, 0, 0, 0, 1, 5'h1f, 0);
    cy(1, 0, 0, 1, 0, 5'h04, 8'h00);
    cy(1, 0, 0, 1, 1, 5'h00, 8'h55);
    cy(0, 0, 0, 0, 1, 5'h04, 0);
    // timer source stays internal: the pin is held still here
    for (int p = 0; p < 16; p++) begin
      cy(1, 4, 9'({2'($urandom), 2'b00, p[3], p[2:0]}), 0, 0, 0, 0);
      t0 = p[3] ? wt : tt;
      repeat (256) cy(1, 0, 0, 0, 0, 0, 0);
      t1 = (p[3] ? wt : tt) - t0;
      e = p[3] ? (256 >> p[2:0]) : (256 >> (p[2:0] + 1));
      chk(t1 >= e - 1 && t1 <= e + 1, "tick count");
    end
    // pin source, rising then falling edges; prescaler on the watchdog
    for (int g = 0; g < 2; g++) begin
      cy(1, 4, g ? 9'h0f8 : 9'h0e8, 0, 0, 0, 0);
      cy(0, 0, 0, 0, 0, 0, 0);
      t0 = tt;
      repeat (8) begin
        i_ext_clk_pin = 1'b1;
        repeat (2) cy(0, 0, 0, 0, 0, 0, 0);
        i_ext_clk_pin = 1'b0;
        repeat (2) cy(0, 0, 0, 0, 0, 0, 0);
      end
      repeat (4) cy(0, 0, 0, 0, 0, 0, 0);
      chk(tt - t0 == 8, "pin tick count");
    end
    rst();
    cy(1, 1, 9'h0aa, 0, 0, 0, 0);
    repeat (3) cy(0, 0, 0, 0, 0, 0, 0);
    give_verdict();
  end
endmodule
bind csc_core csc_core_checker csc_core_checker_inst (.*);
